// file: hw/sams_pkg.sv
/*
 * Constants, field positions and types shared by the scanning converter
 * sequencer top and its self-checking bench.
 * Assumes a single 250 MHz system clock; all times are turned into cycles.
 */
package sams_pkg;
	localparam int CLK_MHZ = 250;
	localparam int NUM_CH = 64;
	localparam int CHAN_NS = 30303;
	localparam int SETTLE_NS = 5000;
	localparam int TRACK_NS = 15000;
	localparam int TRACK_LONG_NS = 28000;
	localparam int CONV_NS = 10000;
	// Least times, rounded up to whole cycles.
	localparam int CHAN_CYC = (CHAN_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int TRACK_CYC = (TRACK_NS * CLK_MHZ + 999) / 1000;
	localparam int TRACK_LONG_CYC = (TRACK_LONG_NS * CLK_MHZ + 999) / 1000;
	localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
	// Register indices on A07..A01.
	localparam logic [6:0] REG_ID = 7'h00;
	localparam logic [6:0] REG_CSR = 7'h01;
	localparam logic [6:0] REG_RESULT = 7'h02;
	localparam logic [6:0] REG_CHAN_BASE = 7'h40;
	// Control and status word fields.
	localparam int CSR_REF_LSB = 0;
	localparam int CSR_MODE_LSB = 2;
	localparam int CSR_MUX_LSB = 5;
	localparam int CSR_START_BIT = 11;
	localparam int CSR_NDR_BIT = 12;
	localparam int CSR_EOS_BIT = 13;
	localparam int CSR_BUSY_BIT = 14;
	localparam int CSR_GDEL_BIT = 15;
	localparam logic [15:0] CSR_CTL_MASK = 16'h87ff;
	localparam logic [15:0] CSR_RESET = 16'h0000;
	typedef enum logic [2:0] {
		MODE_AUTO = 3'h0, MODE_RPOLL = 3'h1, MODE_RINT = 3'h2,
		MODE_SPOLL = 3'h3, MODE_SINT = 3'h4, MODE_RES5 = 3'h5,
		MODE_RES6 = 3'h6, MODE_ABIT = 3'h7
	} sams_mode_t;
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'h0, SEQ_SETTLE = 3'h1, SEQ_TRACK = 3'h3,
		SEQ_CONVERT = 3'h2, SEQ_STORE = 3'h6, SEQ_PACE = 3'h7
	} sams_seq_t;
endpackage

// file: hw/sams_sync.sv
/*
 * Three-stage synchroniser for asynchronous pins.
 * Assumes a synchronous-release active-low reset from the top module.
 */
`timescale 1ns/100ps
module sams_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstN,
	// Pins in, filtered copy out.
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] st1_q;
	logic [WIDTH-1:0] st2_q;
	logic [WIDTH-1:0] st3_q;

	// Shift chain; only the second stage reads the first.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			st1_q <= '0;
			st2_q <= '0;
			st3_q <= '0;
		end else begin
			st1_q <= pinIn;
			st2_q <= st1_q;
			st3_q <= st2_q;
		end
	end

	// A bit changes only once the second and third stages agree.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			syncOut <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (st2_q[i] == st3_q[i]) begin
					syncOut[i] <= st3_q[i];
				end
			end
		end
	end
endmodule // sams_sync

// file: hw/sams_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes DEPTH is a power of two.
 */
`timescale 1ns/100ps
module sams_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstN,
	// Fill side.
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side.
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic push;
	logic pop;

	// Full when pointers differ only in the wrap bit.
	assign inReady = (wrPtr_q[AW] == rdPtr_q[AW]) ||
		(wrPtr_q[AW-1:0] != rdPtr_q[AW-1:0]);
	assign outValid = wrPtr_q != rdPtr_q;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem[rdPtr_q[AW-1:0]];

	// Storage write.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	// Pointer update.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end
endmodule // sams_fifo

// file: hw/sams_top.sv
/*
 * Scanning converter mode sequencer: register slave on the short I/O
 * bus, operating-mode decode, conversion timing, channel result store.
 * Assumes an external board-select comparator, an analog front end
 * driven by the mux and phase outputs, and an interrupter outside.
 */
`timescale 1ns/100ps
module sams_top #(
	parameter int SETTLE_CYC = sams_pkg::SETTLE_CYC,
	parameter int TRACK_CYC = sams_pkg::TRACK_CYC,
	parameter int TRACK_LONG_CYC = sams_pkg::TRACK_LONG_CYC,
	parameter int CONV_CYC = sams_pkg::CONV_CYC,
	parameter int CHAN_CYC = sams_pkg::CHAN_CYC,
	parameter int FIFO_DEPTH = 16,
	parameter logic [15:0] BOARD_ID = 16'h5a00
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Short I/O bus slave.
	input wire logic boardSelect,
	input wire logic [6:0] busAddr,
	input wire logic busWriteN,
	input wire logic busDs0N,
	input wire logic busDs1N,
	input wire logic [15:0] busDataIn,
	output logic [15:0] busDataOut,
	output logic busDataOe,
	output logic busAckOut,
	output logic busAckOe,
	input wire logic iackPassing,
	// Analog front end.
	input wire logic [5:0] scanLengthJumper,
	input wire logic [11:0] adcData,
	output logic [5:0] muxAddr,
	output logic [1:0] refSelect,
	output logic trackEnable,
	output logic convStart,
	// Interrupter requests.
	output logic convIrq,
	output logic scanIrq
);
	localparam int SW = 46;
	localparam int FW = 19;
	logic [1:0] rstPipe_q;
	logic rstN;
	logic [SW-1:0] syncOut;
	logic sel;
	logic [6:0] addrS;
	logic wrNS;
	logic ds0NS;
	logic ds1NS;
	logic [15:0] dinS;
	logic iackS;
	logic [5:0] jumpS;
	logic [11:0] adcS;
	logic ackActive_q;
	logic take;
	logic [15:0] laneMask;
	logic [15:0] csrCtl_q;
	logic [15:0] csrWr;
	logic csrWrite;
	logic startPulse;
	logic modeChange;
	logic [11:0] chanMem [sams_pkg::NUM_CH];
	logic [11:0] result_q;
	logic newData_q;
	logic scanDone_q;
	sams_pkg::sams_mode_t mode;
	logic isAuto;
	logic isSingle;
	logic isRandom;
	sams_pkg::sams_seq_t state_q;
	sams_pkg::sams_seq_t state_d;
	logic [15:0] phaseCnt_q;
	logic [15:0] slotCnt_q;
	logic [5:0] chan_q;
	logic [11:0] sample_q;
	logic phaseDone;
	logic lastChan;
	logic randomDone;
	logic fifoInReady;
	logic fifoOutValid;
	logic [FW-1:0] fifoOut;
	logic drain;

	// Reset released through two flip-flops.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstPipe_q <= 2'h0;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rstN = rstPipe_q[1];

	// Every pin input except clock and reset passes the three-stage synchroniser.
	sams_sync #(
		.WIDTH(SW)
	) u_sync (
		.clk(clk_sys),
		.rstN(rstN),
		.pinIn({boardSelect, busAddr, busWriteN, busDs0N, busDs1N,
			busDataIn, iackPassing, scanLengthJumper, adcData}),
		.syncOut(syncOut)
	);
	assign {sel, addrS, wrNS, ds0NS, ds1NS, dinS, iackS, jumpS,
		adcS} = syncOut;

	// Register read decode, shared by the read path.
	function automatic logic [15:0] regRead(input logic [6:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		if (idx == sams_pkg::REG_ID) begin
			v = BOARD_ID; // Arbitrary identification value.
		end else if (idx == sams_pkg::REG_CSR) begin
			v = csrCtl_q & ~(16'h0001 << sams_pkg::CSR_START_BIT);
			v[sams_pkg::CSR_NDR_BIT] = newData_q;
			v[sams_pkg::CSR_EOS_BIT] = scanDone_q;
			v[sams_pkg::CSR_BUSY_BIT] = state_q != sams_pkg::SEQ_IDLE;
		end else if (idx == sams_pkg::REG_RESULT) begin
			v = {4'h0, result_q};
		end else if (idx >= sams_pkg::REG_CHAN_BASE) begin
			v = {4'h0, chanMem[idx[5:0]]};
		end
		return v;
	endfunction

	// A strobe with board select starts one access
	assign take = sel && (!ds0NS || !ds1NS) && !ackActive_q;
	assign laneMask = {{8{!ds1NS}}, {8{!ds0NS}}};

	// Acknowledge held low until both strobes rise again.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			ackActive_q <= 1'b0;
			busDataOe <= 1'b0;
		end else if (take) begin
			ackActive_q <= 1'b1;
			busDataOe <= wrNS;
		end else if (ds0NS && ds1NS) begin
			ackActive_q <= 1'b0;
			busDataOe <= 1'b0;
		end
	end
	assign busAckOut = 1'b0;
	assign busAckOe = ackActive_q;

	// Read data captured at the take edge.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			busDataOut <= 16'h0000;
		end else if (take && wrNS) begin
			busDataOut <= regRead(addrS);
		end
	end

	// Control half of the shared word, merged by byte lane.
	assign csrWrite = take && !wrNS && addrS == sams_pkg::REG_CSR;
	assign csrWr = (csrCtl_q & ~laneMask) | (dinS & laneMask);
	assign startPulse = csrWrite && csrWr[sams_pkg::CSR_START_BIT];
	assign modeChange = csrWrite &&
		csrWr[sams_pkg::CSR_MODE_LSB +: 3] !=
		csrCtl_q[sams_pkg::CSR_MODE_LSB +: 3];
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			csrCtl_q <= sams_pkg::CSR_RESET;
		end else if (csrWrite) begin
			csrCtl_q <= csrWr & sams_pkg::CSR_CTL_MASK;
		end
	end

	// Mode decode from the three mode bits.
	assign mode = sams_pkg::sams_mode_t'(
		csrCtl_q[sams_pkg::CSR_MODE_LSB +: 3]);
	assign isAuto = mode == sams_pkg::MODE_AUTO ||
		mode == sams_pkg::MODE_ABIT;
	assign isSingle = mode == sams_pkg::MODE_SPOLL ||
		mode == sams_pkg::MODE_SINT;
	assign isRandom = mode == sams_pkg::MODE_RPOLL ||
		mode == sams_pkg::MODE_RINT;

	// Phase length depends on the current phase and gain delay.
	always_comb begin
		phaseDone = 1'b0;
		case (state_q)
			sams_pkg::SEQ_SETTLE:
				phaseDone = phaseCnt_q == 16'(SETTLE_CYC - 1);
			sams_pkg::SEQ_TRACK:
				phaseDone = csrCtl_q[sams_pkg::CSR_GDEL_BIT] ?
					phaseCnt_q == 16'(TRACK_LONG_CYC - 1) :
					phaseCnt_q == 16'(TRACK_CYC - 1);
			sams_pkg::SEQ_CONVERT:
				phaseDone = phaseCnt_q == 16'(CONV_CYC - 1);
			default:
				phaseDone = 1'b0;
		endcase
	end
	assign lastChan = chan_q == jumpS;

	// Sequencer next state.
	always_comb begin
		state_d = state_q;
		case (state_q)
			sams_pkg::SEQ_IDLE: begin
				if (isAuto || ((isSingle || isRandom) && startPulse)) begin
					state_d = sams_pkg::SEQ_SETTLE;
				end
			end
			sams_pkg::SEQ_SETTLE: begin
				if (phaseDone) begin
					state_d = sams_pkg::SEQ_TRACK;
				end
			end
			sams_pkg::SEQ_TRACK: begin
				if (phaseDone) begin
					state_d = sams_pkg::SEQ_CONVERT;
				end
			end
			sams_pkg::SEQ_CONVERT: begin
				if (phaseDone) begin
					state_d = sams_pkg::SEQ_STORE;
				end
			end
			sams_pkg::SEQ_STORE: begin
				if (isRandom) begin
					state_d = sams_pkg::SEQ_IDLE;
				end else if (fifoInReady) begin
					if (lastChan && !isAuto) begin
						state_d = sams_pkg::SEQ_IDLE;
					end else begin
						state_d = sams_pkg::SEQ_PACE;
					end
				end
			end
			sams_pkg::SEQ_PACE: begin
				if (!isAuto || slotCnt_q >= 16'(CHAN_CYC - 1)) begin
					state_d = sams_pkg::SEQ_SETTLE;
				end
			end
			default:
				state_d = sams_pkg::SEQ_IDLE;
		endcase
		if (modeChange) begin
			state_d = sams_pkg::SEQ_IDLE;
		end
	end

	// Sequencer state register.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			state_q <= sams_pkg::SEQ_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Phase timer restarts on every state change.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			phaseCnt_q <= 16'h0000;
		end else if (state_d != state_q) begin
			phaseCnt_q <= 16'h0000;
		end else begin
			phaseCnt_q <= phaseCnt_q + 16'h0001;
		end
	end

	// Channel slot timer, restarted as each channel starts settling.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			slotCnt_q <= 16'h0000;
		end else if (state_d == sams_pkg::SEQ_SETTLE &&
			state_q != sams_pkg::SEQ_SETTLE) begin
			slotCnt_q <= 16'h0000;
		end else if (slotCnt_q != 16'hffff) begin
			slotCnt_q <= slotCnt_q + 16'h0001;
		end
	end

	// Channel counter: host choice in random modes, else ascending.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			chan_q <= 6'h00;
		end else if (state_q == sams_pkg::SEQ_IDLE &&
			state_d == sams_pkg::SEQ_SETTLE) begin
			chan_q <= isRandom ?
				csrCtl_q[sams_pkg::CSR_MUX_LSB +: 6] : 6'h00;
		end else if (state_q == sams_pkg::SEQ_PACE &&
			state_d == sams_pkg::SEQ_SETTLE) begin
			chan_q <= lastChan ? 6'h00 : chan_q + 6'h01;
		end
	end

	// Converter sample taken as the convert phase ends.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			sample_q <= 12'h000;
		end else if (state_q == sams_pkg::SEQ_CONVERT && phaseDone) begin
			sample_q <= adcS;
		end
	end

	// Front-end controls follow the sequencer phase.
	assign muxAddr = chan_q;
	assign trackEnable = state_q == sams_pkg::SEQ_TRACK;
	assign convStart = state_q == sams_pkg::SEQ_CONVERT &&
		phaseCnt_q == 16'h0000;
	assign refSelect = (mode == sams_pkg::MODE_ABIT && chan_q == 6'h00) ?
		csrCtl_q[sams_pkg::CSR_REF_LSB +: 2] : 2'h0;

	// Random result and new-data flag; a set wins over the read clear.
	assign randomDone = state_q == sams_pkg::SEQ_STORE && isRandom;
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			result_q <= 12'h000;
			newData_q <= 1'b0;
		end else if (randomDone) begin
			result_q <= sample_q;
			newData_q <= 1'b1;
		end else if (take && wrNS && addrS == sams_pkg::REG_RESULT) begin
			newData_q <= 1'b0;
		end
	end

	// Scan results queue for the channel store.
	sams_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk_sys),
		.rstN(rstN),
		.inValid(state_q == sams_pkg::SEQ_STORE && !isRandom),
		.inReady(fifoInReady),
		.inData({lastChan && isSingle, chan_q, sample_q}),
		.outValid(fifoOutValid),
		.outReady(!iackS),
		.outData(fifoOut)
	);
	assign drain = fifoOutValid && !iackS;

	// Channel store write.
	always_ff @(posedge clk_sys) begin
		if (drain) begin
			chanMem[fifoOut[17:12]] <= fifoOut[11:0];
		end
	end

	// End-of-scan flag; setting on the last store wins over clearing.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			scanDone_q <= 1'b0;
		end else if (drain && fifoOut[18]) begin
			scanDone_q <= 1'b1;
		end else if (isSingle && startPulse &&
			state_q == sams_pkg::SEQ_IDLE) begin
			scanDone_q <= 1'b0;
		end
	end

	// Interrupt requests, one cycle each, never in reserved modes.
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			convIrq <= 1'b0;
			scanIrq <= 1'b0;
		end else begin
			convIrq <= randomDone && mode == sams_pkg::MODE_RINT;
			scanIrq <= drain && fifoOut[18] &&
				mode == sams_pkg::MODE_SINT;
		end
	end
endmodule // sams_top

// file: verif/sams_assertions.sv
/* Checker for the sequencer top: bus handshake and conversion timing.
   Assumes a bind to sams_top and the sight of its ports only. */
`timescale 1ns/100ps
module sams_assertions #(
	parameter int SETTLE_CYC = 4,
	parameter int TRACK_CYC = 4,
	parameter int TRACK_LONG_CYC = 6
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Bus side.
	input wire logic boardSelect,
	input wire logic busDs0N,
	input wire logic busDs1N,
	input wire logic busDataOe,
	input wire logic busAckOe,
	// Front end and requests.
	input wire logic [5:0] muxAddr,
	input wire logic [1:0] refSelect,
	input wire logic trackEnable,
	input wire logic convStart,
	input wire logic convIrq,
	input wire logic scanIrq
);
	logic [7:0] trackCnt_q;
	logic [7:0] quietCnt_q;
	logic [5:0] muxPrev_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Counts the cycles of the current tracking phase.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) trackCnt_q <= 8'h00;
		else trackCnt_q <= trackEnable ? trackCnt_q + 8'h01 : 8'h00;
	end
	// Counts quiet cycles since the channel last changed.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) quietCnt_q <= 8'h00;
		else if (trackEnable || muxAddr != muxPrev_q) quietCnt_q <= 8'h00;
		else if (quietCnt_q != 8'hff) quietCnt_q <= quietCnt_q + 8'h01;
	end
	// Keeps the previous channel for change detection.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) muxPrev_q <= 6'h00;
		else muxPrev_q <= muxAddr;
	end
	sequence s_stbUp;
		busDs0N && busDs1N;
	endsequence
	sequence s_pulseEnd;
		!convStart;
	endsequence
	property p_ackRelease;
		s_stbUp [*8] |-> !busAckOe;
	endproperty
	property p_noSelect;
		!boardSelect [*8] |-> !busAckOe;
	endproperty
	property p_dataWithAck;
		busDataOe |-> busAckOe;
	endproperty
	property p_trackLen;
		convStart |-> trackCnt_q inside {TRACK_CYC, TRACK_LONG_CYC};
	endproperty
	property p_convPulse;
		convStart |=> s_pulseEnd;
	endproperty
	property p_settle;
		$rose(trackEnable) |-> quietCnt_q >= SETTLE_CYC - 1;
	endproperty
	property p_refCh0;
		refSelect != 2'h0 |-> muxAddr == 6'h00;
	endproperty
	property p_scanIrq;
		scanIrq |-> !convIrq ##1 !scanIrq;
	endproperty
	property p_convIrq;
		convIrq |=> !convIrq;
	endproperty
	a_ackRelease: assert property (p_ackRelease)
		else $error("ack held after strobes rose");
	a_noSelect: assert property (p_noSelect)
		else $error("ack without select");
	a_dataWithAck: assert property (p_dataWithAck)
		else $error("data driven without ack");
	a_trackLen: assert property (p_trackLen)
		else $error("convert without full track");
	a_convPulse: assert property (p_convPulse)
		else $error("convert start too long");
	a_settle: assert property (p_settle)
		else $error("track before settling");
	a_refCh0: assert property (p_refCh0)
		else $error("reference off channel zero");
	a_scanIrq: assert property (p_scanIrq)
		else $error("scan request malformed");
	a_convIrq: assert property (p_convIrq)
		else $error("conversion request too long");
endmodule // sams_assertions
bind sams_top sams_assertions #(.SETTLE_CYC(SETTLE_CYC),
	.TRACK_CYC(TRACK_CYC), .TRACK_LONG_CYC(TRACK_LONG_CYC)) u_chk (
	.clk_sys(clk_sys), .reset_n(reset_n), .boardSelect(boardSelect),
	.busDs0N(busDs0N), .busDs1N(busDs1N), .busDataOe(busDataOe),
	.busAckOe(busAckOe), .muxAddr(muxAddr), .refSelect(refSelect),
	.trackEnable(trackEnable), .convStart(convStart),
	.convIrq(convIrq), .scanIrq(scanIrq));

// file: verif/sams_host.sv
/* Bus master model for the short I/O slave port.
   Assumes the bench calls access() and the slave answers by ack. */
`timescale 1ns/100ps
module sams_host (
	// Clock.
	input wire logic clk,
	// Master outputs.
	output logic boardSelect,
	output logic [6:0] busAddr,
	output logic busWriteN,
	output logic busDs0N,
	output logic busDs1N,
	output logic [15:0] busDataIn,
	// Slave answers.
	input wire logic [15:0] busDataOut,
	input wire logic busAckOe
);
	// Starts with the bus idle.
	initial begin
		boardSelect = 1'b0;
		busAddr = 7'h00;
		busWriteN = 1'b1;
		busDs0N = 1'b1;
		busDs1N = 1'b1;
		busDataIn = 16'h0000;
	end
	// Holds one whole transfer until ack, then waits for its release.
	task automatic access(input logic wr, input logic [6:0] a,
		input logic [15:0] wd, output logic [15:0] rd);
		int n;
		n = 0;
		@(negedge clk);
		boardSelect = 1'b1;
		busAddr = a;
		busWriteN = ~wr;
		busDataIn = wr ? wd : ~busDataIn;
		busDs0N = 1'b0;
		busDs1N = 1'b0;
		while (busAckOe !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		rd = busDataOut;
		@(negedge clk);
		boardSelect = 1'b0;
		busDs0N = 1'b1;
		busDs1N = 1'b1;
		busAddr = ~a;
		busDataIn = ~busDataIn;
		while (busAckOe !== 1'b0 && n < 80) begin
			@(posedge clk);
			n++;
		end
		// Hands control back off the rising edge, so callers drive safely.
		@(negedge clk);
	endtask
endmodule // sams_host

// file: verif/scanning_adc_mode_sequencer_tb.sv
/* Self-checking bench for the scanning converter sequencer.
   Assumes the host model and the bound checker beside the design. */
`timescale 1ns/100ps
module scanning_adc_mode_sequencer_tb;
	localparam int CH = 20;
	localparam int SLOT1 = 4 + 4 + 4 + 2; // Settle, track, convert, store, pace.
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic iackPassing = 1'b0;
	logic boardSelect, busWriteN, busDs0N, busDs1N, busDataOe, busAckOe;
	logic busAckOut, trackEnable, convStart, convIrq, scanIrq;
	logic [6:0] busAddr;
	logic [15:0] busDataIn, busDataOut, rd;
	logic [5:0] jmp = 6'h0f;
	logic [5:0] muxAddr, lastMux;
	logic [11:0] salt = 12'h000;
	logic [1:0] refSelect;
	int seed = 32'h1dad;
	int fail_count = 0;
	int checked = 0;
	int convN = 0, cIrqN = 0, sIrqN = 0, lastConv = 0, cyc = 0, r0, c0;
	bit scanMon = 1'b0;
	int slotLen = CH;
	always #2 clk_sys = ~clk_sys;
	sams_top #(.SETTLE_CYC(4), .TRACK_CYC(4), .TRACK_LONG_CYC(6),
		.CONV_CYC(4), .CHAN_CYC(CH),
		.BOARD_ID(16'h3c3c)) u_dut ( // The identity value is arbitrary.
		.clk_sys(clk_sys), .reset_n(reset_n), .boardSelect(boardSelect),
		.busAddr(busAddr), .busWriteN(busWriteN), .busDs0N(busDs0N),
		.busDs1N(busDs1N), .busDataIn(busDataIn), .busDataOut(busDataOut),
		.busDataOe(busDataOe), .busAckOut(busAckOut), .busAckOe(busAckOe),
		.iackPassing(iackPassing), .scanLengthJumper(jmp),
		.adcData({refSelect, 4'h0, muxAddr} ^ salt), .muxAddr(muxAddr),
		.refSelect(refSelect), .trackEnable(trackEnable),
		.convStart(convStart), .convIrq(convIrq), .scanIrq(scanIrq));
	sams_host u_host (.clk(clk_sys), .boardSelect(boardSelect),
		.busAddr(busAddr), .busWriteN(busWriteN), .busDs0N(busDs0N),
		.busDs1N(busDs1N), .busDataIn(busDataIn),
		.busDataOut(busDataOut), .busAckOe(busAckOe));
	// Expected converter word for a channel and reference choice.
	function automatic logic [15:0] adcOf(logic [5:0] ch, logic [1:0] r);
		return {4'h0, {r, 4'h0, ch} ^ salt};
	endfunction
	// Control word with mode, reference, channel and start fields.
	function automatic logic [15:0] csrw(logic [2:0] md, logic [1:0] r,
		logic [5:0] ch, logic st);
		return {1'b0, 3'h0, st, ch, md, r};
	endfunction
	// Compares one value against its expectation.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Prints the verdict and stops.
	task automatic complete_run();
		if (fail_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Register write and masked read-compare.
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		u_host.access(1'b1, a, d, rd);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [15:0] e,
		input logic [15:0] m);
		u_host.access(1'b0, a, 16'h0000, rd);
		check(rd & m, e & m);
	endtask
	// Reads status until a bit sets, with a bounded count.
	task automatic pollBit(input int b);
		int n;
		n = 0;
		u_host.access(1'b0, sams_pkg::REG_CSR, 16'h0000, rd);
		while (rd[b] !== 1'b1 && n < 200) begin
			u_host.access(1'b0, sams_pkg::REG_CSR, 16'h0000, rd);
			n++;
		end
	endtask
	// Waits one scan and a margin, then checks every scanned channel.
	task automatic scanCheck(input logic [1:0] r);
		repeat ((int'(jmp) + 5) * CH) @(negedge clk_sys);
		for (int ch = 0; ch <= int'(jmp); ch++) begin
			rdc(sams_pkg::REG_CHAN_BASE + 7'(ch), adcOf(6'(ch),
				ch == 0 ? r : 2'h0), 16'h0fff);
		end
	endtask
	// Counts pulses, checks channel order, slot spacing and bus outputs.
	always @(negedge clk_sys) begin
		cyc++;
		if (convIrq === 1'b1) cIrqN++;
		if (scanIrq === 1'b1) sIrqN++;
		if (busAckOe === 1'b1) begin
			check({14'h0, busAckOut, busDataOe}, {15'h0, busWriteN});
		end
		if (convStart === 1'b1) begin
			convN++;
			if (scanMon && lastConv != 0) begin
				check(16'(cyc - lastConv), 16'(slotLen));
				check({10'h0, muxAddr}, {10'h0, lastMux == jmp ? 6'h00 :
					lastMux + 6'h01});
			end
			lastConv = cyc;
			lastMux = muxAddr;
		end
	end
	// Cuts a hang short.
	initial begin
		#200000;
		fail_count++;
		complete_run();
	end
	// Main sequence of scenarios.
	initial begin
		jmp = 6'(15 + {$random(seed)} % 49);
		salt = 12'($random(seed));
		repeat (12) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (8) @(negedge clk_sys);
		rdc(sams_pkg::REG_CSR, 16'h0000, 16'hbfff);
		rdc(7'h03, 16'h0000, 16'hffff);
		wr(sams_pkg::REG_ID, 16'h1234);
		rdc(sams_pkg::REG_ID, 16'h3c3c, 16'hffff);
		lastConv = 0;
		scanMon = 1'b1;
		scanCheck(2'h0);
		scanMon = 1'b0;
		for (int r = 0; r < 4; r++) begin
			wr(sams_pkg::REG_CSR, csrw(3'h7, 2'(r), 6'h00, 1'b0));
			rdc(sams_pkg::REG_CSR, csrw(3'h7, 2'(r), 6'h00, 1'b0),
				sams_pkg::CSR_CTL_MASK);
			scanCheck(2'(r));
		end
		wr(sams_pkg::REG_CSR, csrw(3'h3, 2'h0, 6'h00, 1'b0));
		salt = 12'($random(seed));
		wr(sams_pkg::REG_CSR, csrw(3'h3, 2'h0, 6'h00, 1'b1));
		lastConv = 0;
		slotLen = SLOT1;
		scanMon = 1'b1;
		pollBit(sams_pkg::CSR_EOS_BIT);
		check({15'h0, rd[sams_pkg::CSR_EOS_BIT]}, 16'h0001);
		c0 = convN;
		scanCheck(2'h0);
		check(16'(convN - c0), 16'h0000);
		check(16'(sIrqN + cIrqN), 16'h0000);
		scanMon = 1'b0;
		wr(sams_pkg::REG_CSR, csrw(3'h3, 2'h0, 6'h00, 1'b1));
		rdc(sams_pkg::REG_CSR, 16'h0000, 16'h2000);
		@(negedge clk_sys);
		reset_n = 1'b0;
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (8) @(negedge clk_sys);
		rdc(sams_pkg::REG_CSR, 16'h0000, 16'hbfff);
		wr(sams_pkg::REG_CSR, csrw(3'h4, 2'h0, 6'h00, 1'b0));
		r0 = sIrqN;
		wr(sams_pkg::REG_CSR, csrw(3'h4, 2'h0, 6'h00, 1'b1));
		scanCheck(2'h0);
		check(16'(sIrqN - r0), 16'h0001);
		for (int i = 0; i < 8; i++) begin
			logic [2:0] md;
			logic [5:0] ch;
			md = i < 4 ? 3'h1 : 3'h2;
			ch = i == 0 ? 6'h3f : 6'($random(seed));
			r0 = cIrqN;
			// Odd passes also set the gain-delay bit for the long track.
			wr(sams_pkg::REG_CSR, {i[0], 15'h0} | csrw(md, 2'h0, ch, 1'b0));
			wr(sams_pkg::REG_CSR, {i[0], 15'h0} | csrw(md, 2'h0, ch, 1'b1));
			pollBit(sams_pkg::CSR_NDR_BIT);
			rdc(sams_pkg::REG_RESULT, adcOf(ch, 2'h0), 16'h0fff);
			rdc(sams_pkg::REG_CSR, 16'h0000, 16'h1000);
			check(16'(cIrqN - r0), {15'h0, md == 3'h2});
		end
		for (int md = 5; md < 7; md++) begin
			c0 = convN;
			r0 = cIrqN + sIrqN;
			wr(sams_pkg::REG_CSR, csrw(3'(md), 2'h0, 6'h00, 1'b1));
			repeat (10 * CH) @(negedge clk_sys);
			check(16'(convN - c0), 16'h0000);
			check(16'(cIrqN + sIrqN - r0), 16'h0000);
		end
		wr(sams_pkg::REG_CSR, csrw(3'h0, 2'h0, 6'h00, 1'b0));
		salt = 12'($random(seed));
		iackPassing = 1'b1;
		repeat (40 * CH) @(negedge clk_sys);
		c0 = convN;
		repeat (10 * CH) @(negedge clk_sys);
		check(16'(convN - c0), 16'h0000);
		iackPassing = 1'b0;
		scanCheck(2'h0);
		complete_run();
	end
endmodule // scanning_adc_mode_sequencer_tb
